// *** rtl/pci_ctl.sv ***
// Bus control engine: target claim, single-phase initiator, arbitration and parity errors.
// Function
// - As target, drive device-select active to claim a transaction addressed here.
// - As initiator, watch device-select; abort the cycle if nobody claims in time.
// - Initiator drives frame, asserting it at transaction start; the data phase runs with frame deasserted.
// - Frame deasserted marks the current data phase as the final one.
// - Accept bus ownership from grant even without a pending request (parking).
// - Answer configuration accesses only when the config select input is high.
// - A data phase completes on an edge with initiator ready and either target ready or stop asserted.
// - Drive parity error on data parity mismatch only if command bit 6 set.
// - Assert bus request whenever this device needs to become initiator.
// - Pulse system error on a system error when command bit 8 set.
// - System error may be signalled even when not target of the transaction.
// - Also pulse system error on a card-side address parity error, when enabled.
// - A target may assert stop to end a transaction; the initiator honours it.
// - Even parity over data and byte lines; parity driven one clock after phase.
// - Byte lines carry command in address phase, lane enables in data phases.
module pci_ctl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire pci_ctl_pkg::pin_in_s bus_in,
    input wire logic [31:0] ad_in,
    input wire logic [3:0] cbe_in,
    output pci_ctl_pkg::pin_out_s bus_out,
    output pci_ctl_pkg::pin_oe_s bus_oe,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic [3:0] cbe_out,
    output logic cbe_oe,
    input wire logic [15:0] command_bits,
    input wire logic [pci_ctl_pkg::MEM_BASE_W-1:0] mem_base,
    input wire logic sys_err,
    input wire logic cb_addr_perr,
    input wire logic ini_start,
    input wire logic [3:0] ini_cmd,
    input wire logic [31:0] ini_addr,
    input wire logic [31:0] ini_wdata,
    input wire logic [3:0] ini_be,
    output logic ini_busy,
    output logic ini_done,
    output logic ini_abort,
    output logic ini_stopped,
    output logic [31:0] ini_rdata,
    output logic [31:0] tgt_addr,
    output logic [3:0] tgt_cmd,
    input wire logic [31:0] tgt_rdata,
    output logic tgt_wr,
    output logic tgt_rd,
    output logic [31:0] tgt_wdata,
    output logic [3:0] tgt_be
);
    import pci_ctl_pkg::*;

    state_e st_reg, st_next;
    pin_out_s po_reg, po_next;
    pin_oe_s poe_reg, poe_next;
    logic [31:0] ad_reg, ad_next;
    logic ad_oe_reg, ad_oe_next;
    logic [3:0] cbe_reg, cbe_next;
    logic cbe_oe_reg, cbe_oe_next;
    logic [2:0] cnt_reg, cnt_next;
    logic pend_reg, pend_next;
    logic [3:0] lcmd_reg, lcmd_next;
    logic [31:0] laddr_reg, laddr_next;
    logic [31:0] lwdata_reg, lwdata_next;
    logic [3:0] lbe_reg, lbe_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic abort_reg, abort_next;
    logic stopped_reg, stopped_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] taddr_reg, taddr_next;
    logic [3:0] tcmd_reg, tcmd_next;
    logic twr_reg, twr_next;
    logic trd_reg, trd_next;
    logic [31:0] twdata_reg, twdata_next;
    logic [3:0] tbe_reg, tbe_next;
    logic frame_prev_reg;
    logic chk_reg, chk_next;
    logic chk_due_reg, chk_due_next;
    logic ap_chk_reg;
    logic ap_due_reg;

    logic addr_phase;
    logic bus_idle;
    logic hit;
    logic ini_wr;
    logic tgt_is_wr;
    logic perr_err;
    logic serr_evt;

    always_comb begin
        bus_idle = bus_in.frame_n && bus_in.irdy_n;
        addr_phase = !bus_in.frame_n && frame_prev_reg && bus_in.irdy_n;
        hit = (((cbe_in == CMD_CFG_RD) || (cbe_in == CMD_CFG_WR)) && bus_in.idsel)
            || (((cbe_in == CMD_MEM_RD) || (cbe_in == CMD_MEM_WR))
            && (ad_in[31:MEM_BASE_LSB] == mem_base));
        ini_wr = lcmd_reg[CMD_WRITE_BIT];
        tgt_is_wr = tcmd_reg[CMD_WRITE_BIT];
        // Parity lands one clock after the phase it covers, so the check runs a clock late.
        perr_err = chk_due_reg && (bus_in.par != chk_reg)
            && command_bits[CMDREG_PERR_EN_BIT];
        serr_evt = command_bits[CMDREG_SERR_EN_BIT]
            && ((ap_due_reg && (bus_in.par != ap_chk_reg))
            || sys_err || cb_addr_perr);
    end

    always_comb begin
        st_next = st_reg;
        po_next = PIN_OUT_IDLE;
        poe_next = '0;
        ad_next = ad_reg;
        ad_oe_next = 1'b0;
        cbe_next = cbe_reg;
        cbe_oe_next = 1'b0;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        lcmd_next = lcmd_reg;
        laddr_next = laddr_reg;
        lwdata_next = lwdata_reg;
        lbe_next = lbe_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        abort_next = abort_reg;
        stopped_next = stopped_reg;
        rdata_next = rdata_reg;
        taddr_next = taddr_reg;
        tcmd_next = tcmd_reg;
        twr_next = 1'b0;
        trd_next = 1'b0;
        twdata_next = twdata_reg;
        tbe_next = tbe_reg;
        chk_next = ^{ad_in, cbe_in};
        chk_due_next = 1'b0;

        if (ini_start && !busy_reg) begin
            pend_next = 1'b1;
            busy_next = 1'b1;
            lcmd_next = ini_cmd;
            laddr_next = ini_addr;
            lwdata_next = ini_wdata;
            lbe_next = ini_be;
        end

        unique case (st_reg)
            ST_IDLE: begin
                if (pend_reg && !bus_in.gnt_n && bus_idle) begin
                    st_next = ST_I_ADDR;
                    pend_next = 1'b0;
                    cnt_next = '0;
                    abort_next = 1'b0;
                    stopped_next = 1'b0;
                    po_next.frame_n = 1'b0;
                    poe_next.frame = 1'b1;
                    ad_next = laddr_reg;
                    ad_oe_next = 1'b1;
                    cbe_next = lcmd_reg;
                    cbe_oe_next = 1'b1;
                end else if (addr_phase && hit) begin
                    st_next = ST_T_DEC;
                    taddr_next = ad_in;
                    tcmd_next = cbe_in;
                    po_next.devsel_n = 1'b0;
                    poe_next.devsel = 1'b1;
                    poe_next.trdy = 1'b1;
                    poe_next.stop = 1'b1;
                end else if (!bus_in.gnt_n && !pend_reg && bus_idle) begin
                    // Parked here: keep the shared lines from floating.
                    ad_next = AD_PARK;
                    ad_oe_next = 1'b1;
                    cbe_next = CBE_PARK;
                    cbe_oe_next = 1'b1;
                end
            end
            ST_I_ADDR: begin
                // Single-phase transfers only, so the first data phase is already the last.
                st_next = ST_I_DATA;
                poe_next.frame = 1'b1;
                po_next.irdy_n = 1'b0;
                poe_next.irdy = 1'b1;
                cbe_next = lbe_reg;
                cbe_oe_next = 1'b1;
                ad_next = lwdata_reg;
                ad_oe_next = ini_wr;
            end
            ST_I_DATA: begin
                cnt_next = (cnt_reg == DEVSEL_WINDOW_CYC) ? cnt_reg : cnt_reg + 3'h1;
                if (!bus_in.devsel_n && (!bus_in.trdy_n || !bus_in.stop_n)) begin
                    st_next = ST_I_TURN;
                    done_next = 1'b1;
                    stopped_next = bus_in.trdy_n;
                    po_next.irdy_n = 1'b1;
                    poe_next.irdy = 1'b1;
                    if (!bus_in.trdy_n && !ini_wr) begin
                        rdata_next = ad_in;
                        chk_due_next = 1'b1;
                    end
                end else if (bus_in.devsel_n && (cnt_reg == DEVSEL_WINDOW_CYC - 3'h1)) begin
                    st_next = ST_I_TURN;
                    done_next = 1'b1;
                    abort_next = 1'b1;
                    po_next.irdy_n = 1'b1;
                    poe_next.irdy = 1'b1;
                end else begin
                    poe_next.frame = 1'b1;
                    po_next.irdy_n = 1'b0;
                    poe_next.irdy = 1'b1;
                    cbe_oe_next = 1'b1;
                    ad_oe_next = ini_wr;
                end
            end
            ST_I_TURN: begin
                st_next = ST_IDLE;
                busy_next = pend_next;
            end
            ST_T_DEC: begin
                st_next = ST_T_DATA;
                po_next.devsel_n = 1'b0;
                poe_next.devsel = 1'b1;
                po_next.trdy_n = 1'b0;
                poe_next.trdy = 1'b1;
                // No bursts here: disconnect with the first word if more are framed.
                po_next.stop_n = bus_in.frame_n;
                poe_next.stop = 1'b1;
                ad_next = tgt_rdata;
                ad_oe_next = !tgt_is_wr;
            end
            ST_T_DATA: begin
                poe_next.devsel = 1'b1;
                poe_next.trdy = 1'b1;
                poe_next.stop = 1'b1;
                if (!bus_in.irdy_n) begin
                    twr_next = tgt_is_wr;
                    trd_next = !tgt_is_wr;
                    chk_due_next = tgt_is_wr;
                    if (tgt_is_wr) begin
                        twdata_next = ad_in;
                        tbe_next = cbe_in;
                    end
                    if (bus_in.frame_n) begin
                        st_next = ST_T_TURN;
                    end else begin
                        st_next = ST_T_HOLD;
                        po_next.devsel_n = 1'b0;
                        po_next.stop_n = 1'b0;
                    end
                end else begin
                    po_next.devsel_n = 1'b0;
                    po_next.trdy_n = 1'b0;
                    po_next.stop_n = bus_in.frame_n;
                    ad_oe_next = !tgt_is_wr;
                end
            end
            ST_T_HOLD: begin
                poe_next.devsel = 1'b1;
                poe_next.trdy = 1'b1;
                poe_next.stop = 1'b1;
                if (bus_in.frame_n) begin
                    st_next = ST_T_TURN;
                end else begin
                    po_next.devsel_n = 1'b0;
                    po_next.stop_n = 1'b0;
                end
            end
            ST_T_TURN: begin
                st_next = ST_IDLE;
            end
        endcase

        po_next.req_n = !pend_next;
        po_next.par = chk_next;
        poe_next.par = ad_oe_reg;
        po_next.perr_n = !perr_err;
        // Drive the error line high for one clock after a pulse before letting it float.
        poe_next.perr = perr_err || !po_reg.perr_n;
        po_next.serr_n = !serr_evt;
        poe_next.serr = serr_evt;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            po_reg <= PIN_OUT_IDLE;
            poe_reg <= '0;
            ad_reg <= '0;
            ad_oe_reg <= 1'b0;
            cbe_reg <= '0;
            cbe_oe_reg <= 1'b0;
            cnt_reg <= '0;
            pend_reg <= 1'b0;
            lcmd_reg <= '0;
            laddr_reg <= '0;
            lwdata_reg <= '0;
            lbe_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            abort_reg <= 1'b0;
            stopped_reg <= 1'b0;
            rdata_reg <= '0;
            taddr_reg <= '0;
            tcmd_reg <= '0;
            twr_reg <= 1'b0;
            trd_reg <= 1'b0;
            twdata_reg <= '0;
            tbe_reg <= '0;
            frame_prev_reg <= 1'b1;
            chk_reg <= 1'b0;
            chk_due_reg <= 1'b0;
            ap_chk_reg <= 1'b0;
            ap_due_reg <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
            po_reg <= po_next;
            poe_reg <= poe_next;
            ad_reg <= ad_next;
            ad_oe_reg <= ad_oe_next;
            cbe_reg <= cbe_next;
            cbe_oe_reg <= cbe_oe_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            lcmd_reg <= lcmd_next;
            laddr_reg <= laddr_next;
            lwdata_reg <= lwdata_next;
            lbe_reg <= lbe_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            abort_reg <= abort_next;
            stopped_reg <= stopped_next;
            rdata_reg <= rdata_next;
            taddr_reg <= taddr_next;
            tcmd_reg <= tcmd_next;
            twr_reg <= twr_next;
            trd_reg <= trd_next;
            twdata_reg <= twdata_next;
            tbe_reg <= tbe_next;
            frame_prev_reg <= bus_in.frame_n;
            chk_reg <= chk_next;
            chk_due_reg <= chk_due_next;
            ap_chk_reg <= chk_next;
            ap_due_reg <= addr_phase;
        end
    end

    assign bus_out = po_reg;
    assign bus_oe = poe_reg;
    assign ad_out = ad_reg;
    assign ad_oe = ad_oe_reg;
    assign cbe_out = cbe_reg;
    assign cbe_oe = cbe_oe_reg;
    assign ini_busy = busy_reg;
    assign ini_done = done_reg;
    assign ini_abort = abort_reg;
    assign ini_stopped = stopped_reg;
    assign ini_rdata = rdata_reg;
    assign tgt_addr = taddr_reg;
    assign tgt_cmd = tcmd_reg;
    assign tgt_wr = twr_reg;
    assign tgt_rd = trd_reg;
    assign tgt_wdata = twdata_reg;
    assign tgt_be = tbe_reg;

endmodule : pci_ctl

// *** rtl/pci_ctl_pkg.sv ***
// Shared constants and pin bundles for the parallel bus control engine.
package pci_ctl_pkg;

    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    // Bit 0 of the bus command separates writes from reads for every supported command.
    localparam int CMD_WRITE_BIT = 0;

    // Field positions inside the 16-bit command register value.
    localparam int CMDREG_PERR_EN_BIT = 6;
    localparam int CMDREG_SERR_EN_BIT = 8;

    // Clocks after the address phase within which a target must claim, ending with
    // the subtractive decode slot.
    localparam logic [2:0] DEVSEL_WINDOW_CYC = 3'h5;

    // Memory window: one 4 KiB block whose base the system supplies.
    localparam int MEM_BASE_LSB = 12;
    localparam int MEM_BASE_W = 32 - MEM_BASE_LSB;

    localparam logic [31:0] AD_PARK = 32'h0000_0000;
    localparam logic [3:0] CBE_PARK = 4'h0;

    typedef struct packed {
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
        logic devsel_n;
        logic stop_n;
        logic gnt_n;
        logic idsel;
        logic par;
    } pin_in_s;

    typedef struct packed {
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
        logic devsel_n;
        logic stop_n;
        logic perr_n;
        logic serr_n;
        logic req_n;
        logic par;
    } pin_out_s;

    typedef struct packed {
        logic frame;
        logic irdy;
        logic trdy;
        logic devsel;
        logic stop;
        logic perr;
        logic serr;
        logic par;
    } pin_oe_s;

    localparam pin_out_s PIN_OUT_IDLE = '{frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1,
        devsel_n: 1'b1, stop_n: 1'b1, perr_n: 1'b1, serr_n: 1'b1, req_n: 1'b1, par: 1'b0};

    typedef enum logic [7:0] {
        ST_IDLE   = 8'b0000_0001,
        ST_I_ADDR = 8'b0000_0010,
        ST_I_DATA = 8'b0000_0100,
        ST_I_TURN = 8'b0000_1000,
        ST_T_DEC  = 8'b0001_0000,
        ST_T_DATA = 8'b0010_0000,
        ST_T_HOLD = 8'b0100_0000,
        ST_T_TURN = 8'b1000_0000
    } state_e;

endpackage : pci_ctl_pkg

// *** testbench/pci_ctl_props.sv ***
// Concurrent checks on the bus control engine's pins and user handshake.
module pci_ctl_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire pci_ctl_pkg::pin_in_s bus_in,
    input wire logic [3:0] cbe_in,
    input wire pci_ctl_pkg::pin_out_s bus_out,
    input wire pci_ctl_pkg::pin_oe_s bus_oe,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe,
    input wire logic [3:0] cbe_out,
    input wire logic cbe_oe,
    input wire logic [15:0] command_bits,
    input wire logic sys_err,
    input wire logic cb_addr_perr,
    input wire logic ini_busy,
    input wire logic ini_done,
    input wire logic ini_abort
);
    timeunit 1ns;
    timeprecision 1ps;
    import pci_ctl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Address phase of a configuration cycle started by another initiator.
    sequence s_cfg_addr;
        $fell(bus_in.frame_n) && bus_in.irdy_n && !bus_oe.frame && !ini_busy
            && cbe_in[3:1] == 3'b101;
    endsequence
    sequence s_no_claim;
        (bus_oe.irdy && !bus_out.irdy_n && bus_in.devsel_n) [*5];
    endsequence
    chk_cfg_claim: assert property (
        s_cfg_addr ##0 bus_in.idsel |=> bus_oe.devsel && !bus_out.devsel_n)
        else $error("selected config access not claimed");
    chk_cfg_ignore: assert property (
        s_cfg_addr ##0 !bus_in.idsel |=> (!bus_oe.devsel) [*3])
        else $error("unselected config access claimed");
    chk_frame_start: assert property (
        $rose(bus_oe.frame) |-> !bus_out.frame_n && !$past(bus_in.gnt_n))
        else $error("frame started without grant or inactive");
    chk_last_phase: assert property (
        bus_oe.frame && !bus_out.frame_n |=> bus_out.frame_n && !bus_out.irdy_n)
        else $error("single phase not marked final");
    chk_wait_state: assert property (
        bus_oe.irdy && !bus_out.irdy_n && !bus_in.devsel_n && bus_in.trdy_n && bus_in.stop_n
        |=> !bus_out.irdy_n && !ini_done)
        else $error("data phase ended without target ready");
    chk_abort_bound: assert property (
        s_no_claim |-> ##[1:2] (ini_done && ini_abort))
        else $error("unclaimed cycle not aborted in time");
    chk_stop_honour: assert property (
        bus_oe.irdy && !bus_out.irdy_n && !bus_in.stop_n |=> bus_out.irdy_n && ini_done)
        else $error("stop not honoured");
    chk_req_raise: assert property (
        $rose(ini_busy) |-> !bus_out.req_n)
        else $error("request not raised");
    chk_par_delay: assert property (
        ad_oe && cbe_oe |=> bus_oe.par && bus_out.par == ^{$past(ad_out), $past(cbe_out)})
        else $error("parity wrong or late");
    chk_perr_gate: assert property (
        bus_oe.perr && !bus_out.perr_n |-> command_bits[CMDREG_PERR_EN_BIT])
        else $error("parity error driven while disabled");
    chk_serr_event: assert property (
        (sys_err || cb_addr_perr) && command_bits[CMDREG_SERR_EN_BIT]
        |=> bus_oe.serr && !bus_out.serr_n)
        else $error("system error not pulsed");
    chk_serr_gate: assert property (
        bus_oe.serr |-> $past(command_bits[CMDREG_SERR_EN_BIT]))
        else $error("system error pulsed while disabled");
endmodule : pci_ctl_props

bind pci_ctl pci_ctl_props i_pci_ctl_props (.mclk, .rst_n, .bus_in, .cbe_in, .bus_out,
    .bus_oe, .ad_out, .ad_oe, .cbe_out, .cbe_oe, .command_bits, .sys_err, .cb_addr_perr,
    .ini_busy, .ini_done, .ini_abort);

// *** testbench/pci_far_end.sv ***
// Far-side model: answering target, wire resolution with pull-ups and floating lines.
module pci_far_end #(
    parameter logic [31:0] RD_WORD = 32'h0000_0000
) (
    input wire logic mclk,
    input wire pci_ctl_pkg::pin_out_s bus_out,
    input wire pci_ctl_pkg::pin_oe_s bus_oe,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe,
    input wire logic [3:0] cbe_out,
    input wire logic cbe_oe,
    input wire logic [2:0] claim_dly,
    input wire logic stop_req,
    input wire logic h_oe,
    input wire pci_ctl_pkg::pin_in_s h_pins,
    input wire logic [35:0] h_adc,
    output pci_ctl_pkg::pin_in_s bus_in,
    output logic [31:0] ad_in,
    output logic [3:0] cbe_in,
    output logic [31:0] wr_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    import pci_ctl_pkg::*;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic pr = 1'b0;
    logic lpar = 1'b0;
    logic [2:0] cnt = 3'h0;
    logic [35:0] last = 36'h0_0000_0000;
    logic t_dev, t_go;
    always_comb begin
        // A delay of zero means nobody claims, so the engine must abort.
        t_dev = !(act && claim_dly != 3'h0 && cnt >= claim_dly - 3'h1);
        t_go = act && !t_dev && cnt >= claim_dly;
        bus_in = h_pins;
        bus_in.frame_n = bus_oe.frame ? bus_out.frame_n : !h_oe || h_pins.frame_n;
        bus_in.irdy_n = bus_oe.irdy ? bus_out.irdy_n : !h_oe || h_pins.irdy_n;
        bus_in.devsel_n = bus_oe.devsel ? bus_out.devsel_n : t_dev;
        bus_in.trdy_n = bus_oe.trdy ? bus_out.trdy_n : !(t_go && !stop_req);
        bus_in.stop_n = bus_oe.stop ? bus_out.stop_n : !(t_go && stop_req);
        // Undriven lines show the inverse of their last level.
        {cbe_in, ad_in} = h_oe ? h_adc : ~last;
        if (rd && !t_dev) ad_in = RD_WORD;
        if (ad_oe) ad_in = ad_out;
        if (cbe_oe) cbe_in = cbe_out;
        bus_in.par = h_oe ? h_pins.par : pr ? ^{RD_WORD, last[35:32]} : ~lpar;
        if (bus_oe.par) bus_in.par = bus_out.par;
    end
    always_ff @(posedge mclk) begin
        last <= {cbe_in, ad_in};
        lpar <= bus_in.par;
        pr <= rd && !t_dev;
        if (!act && bus_oe.frame && !bus_out.frame_n) begin
            act <= 1'b1;
            cnt <= 3'h0;
            rd <= !cbe_in[CMD_WRITE_BIT];
        end else if (act) begin
            cnt <= cnt + 3'h1;
            if (!bus_in.irdy_n && (!bus_in.trdy_n || !bus_in.stop_n)) begin
                act <= 1'b0;
                rd <= 1'b0;
                if (!rd) wr_seen <= ad_in;
            end else if (!bus_oe.irdy && cnt > 3'h1) begin
                act <= 1'b0;
                rd <= 1'b0;
            end
        end
    end
endmodule : pci_far_end

// *** testbench/test_pci_bus_control_signalling.sv ***
// Self-checking bench for the bus control engine against its far-side model.
module test_pci_bus_control_signalling;
    timeunit 1ns;
    timeprecision 1ps;
    import pci_ctl_pkg::*;
    localparam logic [31:0] RDW = 32'hC0DE_5A17;
    localparam logic [31:0] TRD = 32'h8765_4321;
    localparam logic [19:0] BASE = 20'h1_2345;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    pin_in_s bus_in;
    pin_in_s h_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    pin_out_s bus_out;
    pin_oe_s bus_oe;
    logic [31:0] ad_in, ad_out, ini_rdata, tgt_addr, tgt_wdata, wr_seen;
    logic [31:0] ini_addr = 32'h0000_1000;
    logic [31:0] ini_wdata = 32'h1234_5678;
    logic [3:0] cbe_in, cbe_out, tgt_be, tgt_cmd;
    logic [3:0] ini_cmd = 4'h0;
    logic [3:0] ini_be = 4'h3;
    logic [15:0] command_bits = 16'h0000;
    logic [35:0] h_adc = 36'h0_0000_0000;
    logic [2:0] claim_dly = 3'h1;
    logic ad_oe, cbe_oe, ini_busy, ini_done, ini_abort, ini_stopped, tgt_wr, tgt_rd;
    logic sys_err = 1'b0;
    logic cb_addr_perr = 1'b0;
    logic ini_start = 1'b0;
    logic stop_req = 1'b0;
    logic h_oe = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    int perr_cnt = 0, serr_cnt = 0;

    always #4 mclk = ~mclk;

    pci_ctl i_pci_ctl (.mclk, .rst_n, .clk_en(1'b1), .bus_in, .ad_in, .cbe_in, .bus_out,
        .bus_oe, .ad_out, .ad_oe, .cbe_out, .cbe_oe, .command_bits, .mem_base(BASE), .sys_err,
        .cb_addr_perr, .ini_start, .ini_cmd, .ini_addr, .ini_wdata, .ini_be, .ini_busy,
        .ini_done, .ini_abort, .ini_stopped, .ini_rdata, .tgt_addr, .tgt_cmd,
        .tgt_rdata(TRD), .tgt_wr, .tgt_rd, .tgt_wdata, .tgt_be);
    pci_far_end #(.RD_WORD(RDW)) i_pci_far_end (.mclk, .bus_out, .bus_oe, .ad_out, .ad_oe,
        .cbe_out, .cbe_oe, .claim_dly, .stop_req, .h_oe, .h_pins, .h_adc, .bus_in, .ad_in,
        .cbe_in, .wr_seen);

    always @(posedge mclk) begin
        perr_cnt <= perr_cnt + int'(bus_oe.perr && !bus_out.perr_n);
        serr_cnt <= serr_cnt + int'(bus_oe.serr);
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // One engine-initiated transfer; a held-off grant shows the request waiting.
    task automatic ini(input logic [3:0] cmd, input logic [2:0] dly, input logic stp,
                       input logic gw);
        int n;
        n = 0;
        @(posedge mclk);
        claim_dly <= dly;
        stop_req <= stp;
        ini_cmd <= cmd;
        ini_addr <= ini_addr + 32'h0000_0104;
        ini_wdata <= ~ini_wdata;
        ini_start <= 1'b1;
        h_pins.gnt_n <= gw;
        @(posedge mclk);
        ini_start <= 1'b0;
        if (gw) begin
            repeat (4) @(posedge mclk);
            check(bus_out.req_n, 1'b0, "req_n");
            check(bus_oe.frame, 1'b0, "frame without grant");
            h_pins.gnt_n <= 1'b0;
        end
        while (ini_done !== 1'b1 && n < 30) begin
            @(posedge mclk);
            n++;
        end
        check(n < 30, 1'b1, "done");
        check(ini_abort, dly == 3'h0, "abort");
        check(ini_stopped, stp && dly != 3'h0, "stopped");
        if (dly != 3'h0 && !stp) begin
            check(cmd[0] ? wr_seen : ini_rdata, cmd[0] ? ini_wdata : RDW, "data");
        end
        h_pins.gnt_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : ini

    // One single-phase transfer from another initiator towards the engine.
    task automatic host(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
                        input logic [1:0] bad, input logic claim);
        logic seen;
        logic [31:0] d;
        int n;
        seen = 1'b0;
        d = addr ^ 32'h5A5A_0F0F;
        n = 0;
        @(posedge mclk);
        h_oe <= 1'b1;
        h_pins.frame_n <= 1'b0;
        h_pins.idsel <= sel;
        h_adc <= {cmd, addr};
        @(posedge mclk);
        h_pins.frame_n <= 1'b1;
        h_pins.irdy_n <= 1'b0;
        h_pins.idsel <= 1'b0;
        h_adc <= {4'h3, d};
        h_pins.par <= ^{cmd, addr} ^ bad[1];
        do begin
            @(posedge mclk);
            n++;
            seen |= !bus_in.devsel_n;
        end while (bus_in.trdy_n && n < 7);
        if (!cmd[0] && claim) check(ad_in, TRD, "target read data");
        h_pins.irdy_n <= 1'b1;
        h_pins.par <= ^{4'h3, d} ^ bad[0];
        @(posedge mclk);
        check({tgt_wr, tgt_rd}, {claim && cmd[0], claim && !cmd[0]}, "target strobes");
        h_oe <= 1'b0;
        repeat (3) @(posedge mclk);
        check(seen, claim, "devsel");
        if (cmd[0] && claim) check({tgt_be, tgt_wdata}, {4'h3, d}, "write lanes");
    endtask : host

    task automatic t_initiator;
        ini(CMD_MEM_WR, 3'h1, 1'b0, 1'b0);
        ini(CMD_MEM_RD, 3'h4, 1'b0, 1'b1);
        ini(CMD_CFG_WR, 3'h0, 1'b0, 1'b0);
        ini(CMD_CFG_RD, 3'h2, 1'b1, 1'b0);
    endtask : t_initiator

    task automatic t_target;
        host(CMD_CFG_WR, 32'h0000_0044, 1'b1, 2'b00, 1'b1);
        check({tgt_cmd, tgt_addr}, {CMD_CFG_WR, 32'h0000_0044}, "tgt_addr");
        host(CMD_CFG_RD, 32'h0000_0048, 1'b0, 2'b00, 1'b0);
        host(CMD_MEM_RD, {BASE, 12'h010}, 1'b0, 2'b00, 1'b1);
        host(CMD_MEM_WR, {BASE ^ 20'h0_0001, 12'h010}, 1'b0, 2'b00, 1'b0);
    endtask : t_target

    // Both enables walk through all four settings; every error source fires each time.
    task automatic t_errors;
        int c;
        for (int i = 0; i < 4; i++) begin
            c = perr_cnt;
            command_bits <= {7'h00, i[1], 1'b0, i[0], 6'h00};
            host(CMD_CFG_WR, 32'h0000_0020, 1'b1, 2'b01, 1'b1);
            check(perr_cnt - c, i[0], "perr pulses");
            c = serr_cnt;
            sys_err <= 1'b1;
            @(posedge mclk);
            sys_err <= 1'b0;
            cb_addr_perr <= 1'b1;
            @(posedge mclk);
            cb_addr_perr <= 1'b0;
            host(CMD_MEM_RD, 32'h0000_0000, 1'b0, 2'b10, 1'b0);
            check(serr_cnt - c, 3 * i[1], "serr pulses");
        end
    endtask : t_errors

    task automatic t_park;
        h_pins.gnt_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check({cbe_oe, ad_oe, cbe_out, ad_out}, {2'b11, CBE_PARK, AD_PARK}, "parked");
        check(bus_out.req_n, 1'b1, "idle request");
        h_pins.gnt_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : t_park

    initial begin
        #20000;
        mismatches++;
        results();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_park();
        t_initiator();
        t_target();
        t_errors();
        results();
    end
endmodule : test_pci_bus_control_signalling
